// ---- hw/serial_port_regs.vh ----
// register map, field positions and timing constants of the serial port
`ifndef SERIAL_PORT_REGS_VH
`define SERIAL_PORT_REGS_VH
// byte addresses on the apb bus
`define ADDR_CTRL 8'h00
`define ADDR_DATA 8'h04
`define ADDR_TIMER 8'h08
`define ADDR_COUNT 8'h0c
`define ADDR_STAT 8'h10
`define ADDR_CLR 8'h14
`define ADDR_IEN 8'h18
// serial_control_reg fields
`define CTRL_FRAME 7
`define CTRL_ONE 6
`define CTRL_QUAL 5
`define CTRL_REN 4
`define CTRL_TB8 3
`define CTRL_RB8 2
`define CTRL_TXF 1
`define CTRL_RXF 0
// timer control fields
`define TMR_RUN 8
`define TMR_SEL_HI 10
`define TMR_SEL_LO 9
// status, clear and enable layout
`define STAT_TX 1
`define STAT_RX 0
// timer clock sources
`define SEL_DIV4 2'h0
`define SEL_DIV12 2'h1
`define SEL_DIV48 2'h2
`define SEL_EXT8 2'h3
// last prescaler count for each source
`define DIV4_LAST 6'h03
`define DIV12_LAST 6'h0b
`define DIV48_LAST 6'h2f
`define EXT8_LAST 3'h7
// 8-bit counter top and reset values
`define CNT_TOP 8'hff
`define RST_BYTE 8'h00
`define RST_SEL 2'h0
// frame bit counts and receive bit indices
`define FRAME8_BITS 4'ha
`define FRAME9_BITS 4'hb
`define RX_LAST8 4'h9
`define RX_LAST9 4'ha
`endif

// ---- hw/baud_timer.v ----
// timer 1 auto-reload counter, its hidden receive copy and baud enables
`timescale 1ns/100ps
`default_nettype none
`include "serial_port_regs.vh"
module baud_timer (
	input wire pclk, // system clock
	input wire presetn, // async reset, active low
	input wire run, // timer 1 enabled
	input wire [1:0] clk_sel, // timer clock source
	input wire ext_osc, // external oscillator level
	input wire [7:0] timer1_reload_value, // reload byte
	input wire rx_restart, // start seen: force receive reload
	output wire [7:0] timer1_low_count, // visible low count
	output reg tx_bit_tick, // one pulse per transmit bit time
	output reg rx_ovf // one pulse per receive timer overflow
);

reg [5:0] pre_r; // system clock prescaler
reg [2:0] ext_cnt_r; // external edge prescaler
reg ext_prev_r; // previous external level
reg [7:0] low_r; // transmit timer
reg [7:0] rxc_r; // receive timer copy
reg tx_half_r; // transmit overflow halver
reg [5:0] last; // prescaler terminal count
reg tick; // timer count enable
wire ext_edge; // rising edge of external clock

assign ext_edge = ext_osc & ~ext_prev_r;
assign timer1_low_count = low_r;

//////////////////////////////////////////////////////////////////////////////
// clock source selection
always @* begin
	tick = 1'b0;
	case (clk_sel)
	`SEL_DIV4: last = `DIV4_LAST;
	`SEL_DIV12: last = `DIV12_LAST;
	default: last = `DIV48_LAST;
	endcase
	if (run) begin
		if (clk_sel == `SEL_EXT8) begin
			tick = ext_edge & (ext_cnt_r == `EXT8_LAST);
		end else begin
			tick = (pre_r == last);
		end
	end
end

//////////////////////////////////////////////////////////////////////////////
// prescalers
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		pre_r <= 6'h00;
		ext_cnt_r <= 3'h0;
		ext_prev_r <= 1'b0;
	end else begin
		ext_prev_r <= ext_osc;
		if (!run || clk_sel == `SEL_EXT8) begin
			pre_r <= 6'h00;
		end else if (pre_r == last) begin
			pre_r <= 6'h00;
		end else begin
			pre_r <= pre_r + 6'h01;
		end
		if (!run) begin
			ext_cnt_r <= 3'h0;
		end else if (ext_edge) begin
			ext_cnt_r <= ext_cnt_r + 3'h1;
		end
	end
end

//////////////////////////////////////////////////////////////////////////////
// 8-bit auto-reload counters and divide-by-two of overflows
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		low_r <= `RST_BYTE;
		rxc_r <= `RST_BYTE;
		tx_half_r <= 1'b0;
		tx_bit_tick <= 1'b0;
		rx_ovf <= 1'b0;
	end else begin
		tx_bit_tick <= 1'b0;
		rx_ovf <= 1'b0;
		if (tick) begin
			if (low_r == `CNT_TOP) begin
				low_r <= timer1_reload_value;
				tx_half_r <= ~tx_half_r;
				tx_bit_tick <= tx_half_r;
			end else begin
				low_r <= low_r + 8'h01;
			end
		end
		if (rx_restart) begin
			rxc_r <= timer1_reload_value;
		end else if (tick) begin
			if (rxc_r == `CNT_TOP) begin
				rxc_r <= timer1_reload_value;
				rx_ovf <= 1'b1;
			end else begin
				rxc_r <= rxc_r + 8'h01;
			end
		end
	end
end

endmodule
`default_nettype wire

// ---- hw/serial_tx.v ----
// transmit shifter of the serial port
`timescale 1ns/100ps
`default_nettype none
`include "serial_port_regs.vh"
module serial_tx (
	input wire pclk, // system clock
	input wire presetn, // async reset, active low
	input wire load, // software wrote the data buffer
	input wire [7:0] data, // byte to send
	input wire nine_mode, // frame_size_select
	input wire tx_ninth_bit, // ninth bit in 9-bit frames
	input wire bit_tick, // one pulse per bit time
	output reg txd, // serial output, idle high
	output reg busy, // frame in progress
	output reg done // pulse at start of stop bit
);

reg [10:0] shift_r; // bits still to send, lsb first
reg [3:0] left_r; // bits still to send

//////////////////////////////////////////////////////////////////////////////
// load, then shift one bit per bit tick
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		shift_r <= 11'h7ff;
		left_r <= 4'h0;
		txd <= 1'b1;
		busy <= 1'b0;
		done <= 1'b0;
	end else begin
		done <= 1'b0;
		if (load && !busy) begin
			busy <= 1'b1;
			if (nine_mode) begin
				shift_r <= {1'b1, tx_ninth_bit, data, 1'b0};
				left_r <= `FRAME9_BITS;
			end else begin
				shift_r <= {1'b1, 1'b1, data, 1'b0};
				left_r <= `FRAME8_BITS;
			end
		end else if (busy && bit_tick) begin
			if (left_r == 4'h0) begin
				busy <= 1'b0; // stop bit finished
				txd <= 1'b1;
			end else begin
				txd <= shift_r[0];
				shift_r <= {1'b1, shift_r[10:1]};
				left_r <= left_r - 4'h1;
				done <= (left_r == 4'h1); // stop bit begins
			end
		end
	end
end

endmodule
`default_nettype wire

// ---- hw/serial_port.v ----
// serial port: apb registers, receiver, flags and interrupt
`timescale 1ns/100ps
`default_nettype none
`include "serial_port_regs.vh"
module serial_port (
	input wire pclk, // apb and core clock
	input wire presetn, // async reset, active low
	input wire psel, // apb select
	input wire penable, // apb access phase
	input wire pwrite, // apb direction
	input wire [7:0] paddr, // apb byte address
	input wire [31:0] pwdata, // apb write data
	output reg [31:0] prdata, // apb read data
	output reg pready, // apb ready
	output reg pslverr, // apb error, unmapped address
	input wire rxd, // serial receive line
	input wire ext_osc, // external oscillator clock
	output wire txd, // serial transmit line
	output reg irq // level interrupt
);

// receiver states, one-hot
localparam RX_IDLE = 2'b01;
localparam RX_BUSY = 2'b10;

//////////////////////////////////////////////////////////////////////////////
// register state
reg frame_size_select_r; // 9-bit frames when set
reg rx_qualify_enable_r; // stop or ninth bit must be one
reg rx_enable_r; // receiver on
reg tx_ninth_bit_r; // ninth transmit bit
reg rx_ninth_bit_r; // received stop or ninth bit
reg [1:0] stat_r; // tx_done_flag and rx_done_flag
reg [1:0] ien_r; // interrupt enables
reg [7:0] timer1_reload_byte_r; // timer reload value
reg timer_run_r; // timer 1 enabled
reg [1:0] clk_sel_r; // timer clock source
reg [7:0] serial_data_buffer_r; // receive buffer

// receiver state
reg [1:0] rx_state_r; // one-hot state
reg rxd_prev_r; // previous line level
reg phase_r; // receive overflow halver
reg [3:0] idx_r; // bit index within frame
reg [8:0] rx_shift_r; // incoming bits, lsb first

// bus decode and combinational values
reg [31:0] rd_val; // read mux result
reg hit; // address maps to a register
reg [1:0] stat_nxt; // next flag state
reg [1:0] flag_set; // hardware set events
reg [1:0] flag_clr; // software clear mask
wire setup; // apb setup cycle
wire wr_en; // write takes effect
wire start_det; // start condition on rxd
wire rx_last; // sample is the final one
wire rx_sample; // sampling point of a bit
wire rx_finish; // final bit sampled
wire qual_bit; // stop bit or ninth bit
wire rx_load; // byte accepted into buffer
wire [3:0] last_idx; // index of final bit
wire tx_load; // write to data address
wire tx_done; // transmitter reached stop bit
wire tx_bit_tick; // transmit bit enable
wire rx_ovf; // receive timer overflow
wire [7:0] timer1_low_count; // visible timer count

assign setup = psel & ~penable;
assign wr_en = psel & penable & pready & pwrite;
assign tx_load = wr_en & (paddr == `ADDR_DATA);

//////////////////////////////////////////////////////////////////////////////
// baud generation and transmitter
baud_timer u_baud (
	.pclk(pclk),
	.presetn(presetn),
	.run(timer_run_r),
	.clk_sel(clk_sel_r),
	.ext_osc(ext_osc),
	.timer1_reload_value(timer1_reload_byte_r),
	.rx_restart(start_det),
	.timer1_low_count(timer1_low_count),
	.tx_bit_tick(tx_bit_tick),
	.rx_ovf(rx_ovf)
);

serial_tx u_tx (
	.pclk(pclk),
	.presetn(presetn),
	.load(tx_load),
	.data(pwdata[7:0]),
	.nine_mode(frame_size_select_r),
	.tx_ninth_bit(tx_ninth_bit_r),
	.bit_tick(tx_bit_tick),
	.txd(txd),
	.busy(),
	.done(tx_done)
);

//////////////////////////////////////////////////////////////////////////////
// receiver control terms
// start only on a falling edge while idle and enabled
assign start_det = rx_enable_r & rx_state_r[0] & rxd_prev_r & ~rxd;
// final bit is the stop bit
assign last_idx = frame_size_select_r ? `RX_LAST9 : `RX_LAST8;
assign rx_sample = rx_state_r[1] & rx_ovf & ~phase_r;
assign rx_last = (idx_r == last_idx);
assign rx_finish = rx_sample & rx_last;
// qualifier: ninth bit in 9-bit frames, stop bit otherwise
assign qual_bit = frame_size_select_r ? rx_shift_r[8] : rxd;
assign rx_load = rx_finish & ~stat_r[`STAT_RX] &
	(~rx_qualify_enable_r | qual_bit);

//////////////////////////////////////////////////////////////////////////////
// receive state machine, runs beside the transmitter
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		rx_state_r <= RX_IDLE;
		rxd_prev_r <= 1'b1;
		phase_r <= 1'b0;
		idx_r <= 4'h0;
		rx_shift_r <= 9'h000;
	end else begin
		rxd_prev_r <= rxd;
		case (rx_state_r)
		RX_IDLE: begin
			if (start_det) begin
				rx_state_r <= RX_BUSY;
				phase_r <= 1'b0; // first overflow is mid start bit
				idx_r <= 4'h0;
			end
		end
		RX_BUSY: begin
			if (!rx_enable_r) begin
				rx_state_r <= RX_IDLE; // receiver switched off
			end else if (rx_ovf) begin
				phase_r <= ~phase_r;
				if (!phase_r) begin
					if (idx_r == 4'h0 && rxd) begin
						rx_state_r <= RX_IDLE; // false start
					end else if (rx_last) begin
						rx_state_r <= RX_IDLE; // frame done
					end else begin
						idx_r <= idx_r + 4'h1;
						if (idx_r != 4'h0) begin
							// data bits arrive lsb first
							rx_shift_r <= {rxd, rx_shift_r[8:1]};
						end
					end
				end
			end
		end
		default: begin
			rx_state_r <= RX_IDLE;
		end
		endcase
	end
end

//////////////////////////////////////////////////////////////////////////////
// receive buffer: holds one byte while the next is shifted in
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		serial_data_buffer_r <= `RST_BYTE;
		rx_ninth_bit_r <= 1'b0;
	end else if (rx_load) begin
		if (frame_size_select_r) begin
			serial_data_buffer_r <= rx_shift_r[7:0];
		end else begin
			serial_data_buffer_r <= rx_shift_r[8:1];
		end
		rx_ninth_bit_r <= qual_bit;
	end
end

//////////////////////////////////////////////////////////////////////////////
// done flags: hardware sets, software clears, set wins
always @* begin
	flag_set = 2'h0;
	flag_clr = 2'h0;
	flag_set[`STAT_TX] = tx_done;
	flag_set[`STAT_RX] = rx_load;
	if (wr_en && paddr == `ADDR_CLR) begin
		flag_clr = pwdata[1:0];
	end
	stat_nxt = (stat_r & ~flag_clr) | flag_set;
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		stat_r <= 2'h0;
		irq <= 1'b0;
	end else begin
		stat_r <= stat_nxt;
		irq <= |(stat_r & ien_r);
	end
end

//////////////////////////////////////////////////////////////////////////////
// software-written control registers
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		frame_size_select_r <= 1'b0;
		rx_qualify_enable_r <= 1'b0;
		rx_enable_r <= 1'b0;
		tx_ninth_bit_r <= 1'b0;
		ien_r <= 2'h0;
		timer1_reload_byte_r <= `RST_BYTE;
		timer_run_r <= 1'b0;
		clk_sel_r <= `RST_SEL;
	end else if (wr_en) begin
		if (paddr == `ADDR_CTRL) begin
			// flag and ninth receive bits are read-only here
			frame_size_select_r <= pwdata[`CTRL_FRAME];
			rx_qualify_enable_r <= pwdata[`CTRL_QUAL];
			rx_enable_r <= pwdata[`CTRL_REN];
			tx_ninth_bit_r <= pwdata[`CTRL_TB8];
		end else if (paddr == `ADDR_TIMER) begin
			// reload chosen by software for twice the baud rate
			timer1_reload_byte_r <= pwdata[7:0];
			timer_run_r <= pwdata[`TMR_RUN];
			clk_sel_r <= pwdata[`TMR_SEL_HI:`TMR_SEL_LO];
		end else if (paddr == `ADDR_IEN) begin
			ien_r <= pwdata[1:0];
		end
	end
end

//////////////////////////////////////////////////////////////////////////////
// read mux and address decode
always @* begin
	rd_val = 32'h0000_0000;
	hit = 1'b1;
	if (paddr == `ADDR_CTRL) begin
		rd_val[`CTRL_FRAME] = frame_size_select_r;
		rd_val[`CTRL_ONE] = 1'b1; // unused bit reads one
		rd_val[`CTRL_QUAL] = rx_qualify_enable_r;
		rd_val[`CTRL_REN] = rx_enable_r;
		rd_val[`CTRL_TB8] = tx_ninth_bit_r;
		rd_val[`CTRL_RB8] = rx_ninth_bit_r;
		rd_val[`CTRL_TXF] = stat_r[`STAT_TX];
		rd_val[`CTRL_RXF] = stat_r[`STAT_RX];
	end else if (paddr == `ADDR_DATA) begin
		rd_val[7:0] = serial_data_buffer_r;
	end else if (paddr == `ADDR_TIMER) begin
		rd_val[7:0] = timer1_reload_byte_r;
		rd_val[`TMR_RUN] = timer_run_r;
		rd_val[`TMR_SEL_HI:`TMR_SEL_LO] = clk_sel_r;
	end else if (paddr == `ADDR_COUNT) begin
		rd_val[7:0] = timer1_low_count;
	end else if (paddr == `ADDR_STAT) begin
		rd_val[1:0] = stat_r;
	end else if (paddr == `ADDR_CLR) begin
		rd_val = 32'h0000_0000; // write-only, reads zero
	end else if (paddr == `ADDR_IEN) begin
		rd_val[1:0] = ien_r;
	end else begin
		hit = 1'b0; // unmapped address
	end
end

//////////////////////////////////////////////////////////////////////////////
// apb answer: ready in the first access cycle
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		pready <= 1'b0;
		pslverr <= 1'b0;
		prdata <= 32'h0000_0000;
	end else begin
		pready <= setup;
		pslverr <= setup & ~hit;
		if (setup && !pwrite) begin
			prdata <= rd_val;
		end
	end
end

endmodule
`default_nettype wire

// ---- verif/serial_port_assertions.sv ----
// checker for the serial port bus handshake, interrupt and transmit line
`timescale 1ns/100ps
`default_nettype none
module serial_port_checker (
	input wire pclk, // clock
	input wire presetn, // async reset, active low
	input wire psel, // apb select
	input wire penable, // apb access phase
	input wire pwrite, // apb direction
	input wire [7:0] paddr, // apb byte address
	input wire [31:0] pwdata, // apb write data
	input wire [31:0] prdata, // apb read data
	input wire pready, // apb ready
	input wire pslverr, // apb error
	input wire txd, // serial transmit line
	input wire irq // level interrupt
);
	////////////////////////////////////////////////////////////////////////
	wire setup = psel && !penable; // setup cycle of a transfer
	reg [1:0] ien_r; // shadow of the interrupt enable register

	// follow writes to the interrupt enable register
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ien_r <= 2'h0;
		end else if (psel && penable && pready && pwrite && paddr == 8'h18) begin
			ien_r <= pwdata[1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	AST_READY_NEXT: assert property (setup |=> pready)
		else $error("pready missing after setup");
	AST_READY_PULSE: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	AST_READY_CAUSE: assert property (pready |-> $past(setup))
		else $error("pready without setup");
	AST_ERR_READY: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	AST_UNMAPPED: assert property (setup && paddr > 8'h18 |=> pslverr)
		else $error("unmapped address not refused");
	AST_MAPPED_OK: assert property (
		setup && paddr <= 8'h18 && paddr[1:0] == 2'h0 |=> !pslverr)
		else $error("mapped address refused");
	AST_RDATA_HOLD: assert property (
		!$past(setup && !pwrite) |-> $stable(prdata))
		else $error("read data changed without a read");
	AST_IRQ_MASK: assert property (
		ien_r == 2'h0 && $past(ien_r) == 2'h0 |-> !irq)
		else $error("interrupt raised while disabled");
	AST_TX_BIT_MIN: assert property ($fell(txd) |-> (!txd) [*8])
		else $error("start bit shorter than two overflows");
	AST_TXD_RESET: assert property ($rose(presetn) |-> txd)
		else $error("transmit line not idle after reset");

	COV_IRQ: cover property ($rose(irq));
	COV_ERR: cover property (pslverr);
	COV_FRAME: cover property ($fell(txd));
endmodule
bind serial_port serial_port_checker serial_port_checker_inst (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .txd(txd), .irq(irq));
`default_nettype wire

// ---- verif/remote_uart.sv ----
// behavioural remote transceiver on the serial lines
`timescale 1ns/100ps
`default_nettype none
module remote_uart (
	input wire logic pclk, // bench clock
	input wire logic line_in, // design transmit line
	output logic line_out // design receive line
);
	int bit_cyc = 16; // clocks per bit, set by the bench
	logic nine = 1'b0; // 9-bit frames when set
	logic [8:0] got = 9'h0; // data plus ninth or stop bit
	int got_n = 0; // frames captured so far
	initial line_out = 1'b1; // line idles high

	////////////////////////////////////////////////////////////////////////
	// capture: a falling edge starts a frame, sample each bit mid-way
	always begin
		@(negedge line_in);
		repeat (bit_cyc / 2) @(posedge pclk);
		for (int i = 0; i < 9; i++) begin
			repeat (bit_cyc) @(posedge pclk);
			got[i] = line_in;
		end
		got_n++;
	end

	// send a frame lsb first; the top bit is stop in 9-bit, idle in 8-bit
	task automatic send(input logic [7:0] d, input logic b9);
		logic [10:0] f;
		f = {1'b1, b9, d, 1'b0};
		for (int i = 0; i < 11; i++) begin
			line_out <= f[i];
			repeat (bit_cyc) @(posedge pclk);
		end
	endtask
endmodule
`default_nettype wire

// ---- verif/tb_serial_port.sv ----
// self-checking bench for the serial port
`timescale 1ns/100ps
`default_nettype none
`include "serial_port_regs.vh"
module tb_serial_port;
	logic pclk, presetn, psel, penable, pwrite, rxd, txd, irq;
	logic ext_osc = 1'b0; // external oscillator level, one driver only
	logic pready, pslverr, perr; // bus answer and last error
	logic [7:0] paddr, last; // address, last loaded byte
	logic [31:0] pwdata, prdata, v, junk; // bus data
	logic [1:0] ext_div = 2'h0; // external oscillator divider
	int mismatches = 0;
	int compares = 0;
	int n0; // frame count before a row
	typedef struct packed {
		logic [1:0] sel;
		logic [7:0] rld;
		logic nine;
		logic qual;
		logic b9;
		logic [7:0] d;
		logic ld;
	} row_t;
	row_t r;
	// clock source, reload, frame, qualify, ninth/stop, data, loaded
	row_t rows [7] = '{
		'{2'h0, 8'hfe, 1'b0, 1'b0, 1'b1, 8'ha5, 1'b1},
		'{2'h0, 8'hfd, 1'b0, 1'b1, 1'b0, 8'h3c, 1'b0},
		'{2'h1, 8'hff, 1'b1, 1'b1, 1'b1, 8'h81, 1'b1},
		'{2'h1, 8'hfe, 1'b1, 1'b1, 1'b0, 8'h7e, 1'b0},
		'{2'h2, 8'hff, 1'b1, 1'b0, 1'b0, 8'h01, 1'b1},
		'{2'h3, 8'hff, 1'b0, 1'b0, 1'b1, 8'hfe, 1'b1},
		'{2'h0, 8'hfe, 1'b0, 1'b0, 1'b0, 8'h55, 1'b1}};

	serial_port serial_port_inst (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rxd(rxd), .ext_osc(ext_osc), .txd(txd),
		.irq(irq));
	remote_uart remote_uart_inst (.pclk(pclk), .line_in(txd),
		.line_out(rxd));

	////////////////////////////////////////////////////////////////////////
	// clock, and an external oscillator at a quarter of its rate
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		ext_div <= ext_div + 2'h1;
		ext_osc <= ext_div[1];
	end

	////////////////////////////////////////////////////////////////////////
	task automatic wrap_up;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	// compare and report
	task automatic chk(input string nm, input logic [31:0] ex,
		input logic [31:0] got);
		compares++;
		if (got !== ex) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", nm, ex, got);
		end
	endtask

	// one apb transfer; holds the request until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rdat);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rdat = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) begin
			chk("pready", 1, 0);
			wrap_up();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, junk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		apb(1'b0, a, 32'h0, d);
	endtask

	// bit time: two overflows of (256 - reload) timer clocks
	function automatic int bit_len(input logic [1:0] s, input logic [7:0] rl);
		int dv;
		dv = (s == `SEL_DIV4) ? 4 : (s == `SEL_DIV12) ? 12 :
			(s == `SEL_DIV48) ? 48 : 32;
		return 2 * (256 - rl) * dv;
	endfunction

	// poll until transmit done is flagged and the frame was captured
	task automatic wait_done(input int n);
		int k;
		k = 0;
		v = 32'h0;
		while ((v[`STAT_TX] !== 1'b1 || remote_uart_inst.got_n == n)
			&& k < 800) begin
			rd(`ADDR_STAT, v);
			k++;
		end
		// let the stop bit run out: a data write while busy is dropped
		if (k < 800) repeat (remote_uart_inst.bit_cyc) @(posedge pclk);
		if (k >= 800) begin
			chk("frame wait", 1, 0);
			wrap_up();
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		// reset values and a refused address
		rd(`ADDR_CTRL, v);
		chk("ctrl reset", 32'h40, v);
		rd(`ADDR_TIMER, v);
		chk("timer reset", 32'h0, v);
		rd(`ADDR_STAT, v);
		chk("status reset", 32'h0, v);
		chk("txd idle", 1, txd);
		rd(8'h1c, v);
		chk("unmapped error", 1, perr);
		chk("unmapped data", 0, v);
		wr(`ADDR_IEN, 32'h3);
		// full duplex frames across clock sources and frame modes
		foreach (rows[i]) begin
			r = rows[i];
			wr(`ADDR_TIMER, {21'h0, r.sel, 1'b1, r.rld});
			wr(`ADDR_CTRL, {24'h0, r.nine, 1'b0, r.qual, 1'b1, r.b9, 3'h0});
			remote_uart_inst.bit_cyc = bit_len(r.sel, r.rld);
			remote_uart_inst.nine = r.nine;
			n0 = remote_uart_inst.got_n;
			fork
				wr(`ADDR_DATA, {24'h0, r.d});
				remote_uart_inst.send(r.d, r.b9);
			join
			wait_done(n0);
			chk("tx frame", {r.nine ? r.b9 : 1'b1, r.d},
				remote_uart_inst.got);
			rd(`ADDR_STAT, v);
			chk("status", {30'h0, 1'b1, r.ld}, v);
			chk("irq set", 1, irq);
			if (r.ld) last = r.d;
			rd(`ADDR_DATA, v);
			chk("rx data", last, v);
			rd(`ADDR_CTRL, v);
			if (r.ld) chk("rx ninth", r.b9, v[`CTRL_RB8]);
			wr(`ADDR_CLR, 32'h3);
			rd(`ADDR_STAT, v);
			chk("cleared", 0, v);
			chk("irq clear", 0, irq);
		end
		// overrun: second byte is dropped while the first waits
		wr(`ADDR_TIMER, 32'h1fe);
		wr(`ADDR_CTRL, 32'h10);
		remote_uart_inst.bit_cyc = 16;
		remote_uart_inst.nine = 1'b0;
		remote_uart_inst.send(8'h11, 1'b1);
		remote_uart_inst.send(8'h22, 1'b1);
		rd(`ADDR_DATA, v);
		chk("overrun data", 32'h11, v);
		// masking with the receive flag standing
		wr(`ADDR_IEN, 32'h0);
		rd(`ADDR_STAT, v);
		chk("rx sticky", 32'h1, v);
		chk("irq masked", 0, irq);
		wr(`ADDR_IEN, 32'h2);
		rd(`ADDR_STAT, v);
		chk("irq other", 0, irq);
		wr(`ADDR_IEN, 32'h1);
		rd(`ADDR_STAT, v);
		chk("irq enabled", 1, irq);
		wr(`ADDR_CLR, 32'h1);
		remote_uart_inst.send(8'h33, 1'b1);
		rd(`ADDR_DATA, v);
		chk("after clear", 32'h33, v);
		// reset in mid-run with the receive flag and interrupt standing
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd(`ADDR_STAT, v);
		chk("rerun status", 32'h0, v);
		chk("rerun irq", 0, irq);
		rd(`ADDR_CTRL, v);
		chk("rerun ctrl", 32'h40, v);
		rd(`ADDR_TIMER, v);
		chk("rerun timer", 32'h0, v);
		chk("rerun txd", 1, txd);
		wrap_up();
	end
endmodule
`default_nettype wire
